// file: core/analog_monitor_output_scaler.sv
// Two-channel analog monitor scaler with its APB register file
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "monitor_map.svh"

module analog_monitor_output_scaler
#(
  parameter int ADDR_W = 8
)
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // APB answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Drive quantities and mode
  input wire monitor_pkg::quantities_type drive_in,
  input wire logic speed_ctrl_mode,
  // Monitor outputs in millivolts and their clamp flags
  output logic signed [15:0] monitor_one_mv,
  output logic signed [15:0] monitor_two_mv,
  output logic [1:0] clamp_active
);

  monitor_pkg::chan_cfg_type cfg_ff [2];
  monitor_pkg::sources_type src;
  logic signed [15:0] gravity_ff;
  logic signed [15:0] chan_mv [2];
  logic [1:0] chan_clamp;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_rdata;
  logic pslverr_ff;
  logic nxt_err;
  logic setup_phase;
  logic access_phase;
  logic wr_commit;
  logic signed [15:0] off_new [2];
  logic signed [15:0] grav_new;
  logic after_rst_ff;

  // ************************************************************
  // Byte lane merge
  // ************************************************************

  // Apply the two low byte strobes to a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = wd[7:0];
    if (strb[1])
      res[15:8] = wd[15:8];
    return res;
  endfunction : merge16

  // ************************************************************
  // APB phases
  // ************************************************************

  // Phase decode and write commit
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready = access_phase;
  assign wr_commit = access_phase & pwrite & ~pslverr_ff;

  // Candidate wide values after the byte strobes
  assign off_new[0] = merge16(cfg_ff[0].offset, pwdata, pstrb);
  assign off_new[1] = merge16(cfg_ff[1].offset, pwdata, pstrb);
  assign grav_new = merge16(gravity_ff, pwdata, pstrb);

  // Read data and refusal for the addressed register
  always_comb
  begin
    nxt_rdata = 32'h0;
    nxt_err = 1'b0;
    case (paddr)
      ADDR_W'(`OFF_SEL_ONE):
        nxt_rdata = {27'h0, cfg_ff[0].sel};
      ADDR_W'(`OFF_SEL_TWO):
        nxt_rdata = {27'h0, cfg_ff[1].sel};
      ADDR_W'(`OFF_GAIN_ONE):
      begin
        nxt_rdata = {28'h0, cfg_ff[0].gain};
        nxt_err = pwrite & pstrb[0] & (pwdata[3:0] > `GAIN_DIV100);
      end
      ADDR_W'(`OFF_GAIN_TWO):
      begin
        nxt_rdata = {28'h0, cfg_ff[1].gain};
        nxt_err = pwrite & pstrb[0] & (pwdata[3:0] > `GAIN_DIV100);
      end
      ADDR_W'(`OFF_OFFSET_ONE):
      begin
        nxt_rdata = {16'h0, cfg_ff[0].offset};
        nxt_err = pwrite & ((off_new[0] > `OFFSET_MAX) |
                            (off_new[0] < `OFFSET_MIN));
      end
      ADDR_W'(`OFF_OFFSET_TWO):
      begin
        nxt_rdata = {16'h0, cfg_ff[1].offset};
        nxt_err = pwrite & ((off_new[1] > `OFFSET_MAX) |
                            (off_new[1] < `OFFSET_MIN));
      end
      ADDR_W'(`OFF_GRAVITY):
        nxt_rdata = {16'h0, gravity_ff};
      ADDR_W'(`OFF_OUT_ONE):
      begin
        nxt_rdata = {16'h0, chan_mv[0]};
        nxt_err = pwrite;
      end
      ADDR_W'(`OFF_OUT_TWO):
      begin
        nxt_rdata = {16'h0, chan_mv[1]};
        nxt_err = pwrite;
      end
      ADDR_W'(`OFF_STATUS):
      begin
        nxt_rdata[`STAT_CLAMP_ONE] = chan_clamp[0];
        nxt_rdata[`STAT_CLAMP_TWO] = chan_clamp[1];
        nxt_err = pwrite;
      end
      default:
        nxt_err = 1'b1;
    endcase
  end

  // Answer captured in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_ff <= pwrite ? 32'h0 : nxt_rdata;
      pslverr_ff <= nxt_err;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = access_phase & pslverr_ff;

  // ************************************************************
  // Settings registers
  // ************************************************************

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    localparam logic [7:0] SEL_OFF = (ch == 0) ? `OFF_SEL_ONE : `OFF_SEL_TWO;
    localparam logic [7:0] GAIN_OFF =
      (ch == 0) ? `OFF_GAIN_ONE : `OFF_GAIN_TWO;
    localparam logic [7:0] OFS_OFF =
      (ch == 0) ? `OFF_OFFSET_ONE : `OFF_OFFSET_TWO;
    localparam logic [4:0] SEL_RST = (ch == 0) ? `RST_SEL_ONE : `RST_SEL_TWO;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg_ff[ch].sel <= SEL_RST;
      else if (wr_commit && pstrb[0] && paddr == ADDR_W'(SEL_OFF))
        cfg_ff[ch].sel <= pwdata[4:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg_ff[ch].gain <= `RST_GAIN;
      else if (wr_commit && pstrb[0] && paddr == ADDR_W'(GAIN_OFF))
        cfg_ff[ch].gain <= pwdata[3:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg_ff[ch].offset <= `RST_OFFSET;
      else if (wr_commit && paddr == ADDR_W'(OFS_OFF))
        cfg_ff[ch].offset <= off_new[ch];
    end

    monitor_scale_chan u_chan
    (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_ff[ch]),
      .src(src),
      .volt_mv_ff(chan_mv[ch]),
      .clamped_ff(chan_clamp[ch])
    );

    property p_gain_range;
      @(posedge pclk) disable iff (!presetn)
      cfg_ff[ch].gain <= `GAIN_DIV100;
    endproperty
    a_gain_range: assert property (p_gain_range)
      else $error("gain field above 4");
  end

  // Gravity compensation torque, 0.1 % units
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gravity_ff <= `RST_GRAVITY;
    else if (wr_commit && paddr == ADDR_W'(`OFF_GRAVITY))
      gravity_ff <= grav_new;
  end

  // Marks the first edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      after_rst_ff <= 1'b0;
    else
      after_rst_ff <= 1'b1;
  end

  // ************************************************************
  // Quantity bundle
  // ************************************************************

  // Gather quantities and mode for both channels
  always_comb
  begin
    src = '0;
    src.motor_speed = drive_in.motor_speed;
    src.speed_cmd = drive_in.speed_cmd;
    src.torque_net = 17'(drive_in.torque_cmd) - 17'(gravity_ff);
    src.pos_dev = drive_in.pos_dev;
    src.pos_amp_dev = drive_in.pos_amp_dev;
    src.pos_cmd_speed = drive_in.pos_cmd_speed;
    src.speed_ff = drive_in.speed_ff;
    src.torque_ff = drive_in.torque_ff;
    src.positioning_done = drive_in.positioning_done;
    src.speed_ctrl = speed_ctrl_mode;
  end

  // Outputs
  assign monitor_one_mv = chan_mv[0];
  assign monitor_two_mv = chan_mv[1];
  assign clamp_active = chan_clamp;

  // ************************************************************
  // Checks
  // ************************************************************

  property p_offset_one;
    @(posedge pclk) disable iff (!presetn)
    cfg_ff[0].offset <= `OFFSET_MAX && cfg_ff[0].offset >= `OFFSET_MIN;
  endproperty
  a_offset_one: assert property (p_offset_one)
    else $error("channel one offset out of range");

  property p_offset_two;
    @(posedge pclk) disable iff (!presetn)
    cfg_ff[1].offset <= `OFFSET_MAX && cfg_ff[1].offset >= `OFFSET_MIN;
  endproperty
  a_offset_two: assert property (p_offset_two)
    else $error("channel two offset out of range");

  property p_sel_default;
    @(posedge pclk) disable iff (!presetn)
    !after_rst_ff |-> cfg_ff[0].sel == 5'h02 && cfg_ff[1].sel == 5'h00;
  endproperty
  a_sel_default: assert property (p_sel_default)
    else $error("selection reset default wrong");

  property p_sel_apply;
    @(posedge pclk) disable iff (!presetn)
    wr_commit && pstrb[0] && paddr == ADDR_W'(`OFF_SEL_TWO) |=>
      cfg_ff[1].sel == $past(pwdata[4:0]);
  endproperty
  a_sel_apply: assert property (p_sel_apply)
    else $error("selection write not applied");

  property p_bad_gain;
    @(posedge pclk) disable iff (!presetn)
    setup_phase && pwrite && pstrb[0] && pwdata[3:0] == 4'h5 &&
      paddr == ADDR_W'(`OFF_GAIN_ONE) |=>
      pslverr && $stable(cfg_ff[0].gain) ##1 $stable(cfg_ff[0].gain);
  endproperty
  a_bad_gain: assert property (p_bad_gain)
    else $error("gain 5 was not refused");

  property p_torque_path;
    @(posedge pclk) disable iff (!presetn)
    cfg_ff[0].sel == `SEL_TORQUE_CMD && cfg_ff[0].gain == `GAIN_UNITY &&
      cfg_ff[0].offset == 16'sh0000 && gravity_ff == 16'sh0000 &&
      drive_in.torque_cmd < 16'sh1f40 && drive_in.torque_cmd > -16'sh1f40
      ##1 $stable(cfg_ff[0]) |=>
      monitor_one_mv == $past(drive_in.torque_cmd, 2);
  endproperty
  a_torque_path: assert property (p_torque_path)
    else $error("torque output does not follow input");

endmodule : analog_monitor_output_scaler

// file: core/monitor_map.svh
// Register offsets, reset values, codes and scale figures for the monitor
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

// Register byte offsets
`define OFF_SEL_ONE 8'h00
`define OFF_SEL_TWO 8'h04
`define OFF_GAIN_ONE 8'h08
`define OFF_GAIN_TWO 8'h0c
`define OFF_OFFSET_ONE 8'h10
`define OFF_OFFSET_TWO 8'h14
`define OFF_GRAVITY 8'h18
`define OFF_OUT_ONE 8'h1c
`define OFF_OUT_TWO 8'h20
`define OFF_STATUS 8'h24

// Status field positions
`define STAT_CLAMP_ONE 0
`define STAT_CLAMP_TWO 1

// Reset values
`define RST_SEL_ONE 5'h02
`define RST_SEL_TWO 5'h00
`define RST_GAIN 4'h0
`define RST_OFFSET 16'h0000
`define RST_GRAVITY 16'h0000

// Signal selection codes
`define SEL_MOTOR_SPEED 5'h00
`define SEL_SPEED_CMD 5'h01
`define SEL_TORQUE_CMD 5'h02
`define SEL_POS_DEV 5'h03
`define SEL_AMP_DEV 5'h04
`define SEL_POS_CMD_SPEED 5'h05
`define SEL_POS_DONE 5'h08
`define SEL_SPEED_FF 5'h09
`define SEL_TORQUE_FF 5'h0a

// Gain multiplier codes
`define GAIN_UNITY 4'h0
`define GAIN_X10 4'h1
`define GAIN_X100 4'h2
`define GAIN_DIV10 4'h3
`define GAIN_DIV100 4'h4

// Base scales in millivolts per input unit, then done level, gain factors and offset step
`define SCALE_SPEED 40'sh1
`define SCALE_TORQUE 40'sh1
`define SCALE_DEV 40'sh32
`define DONE_MV 40'sh1388
`define GAIN_TEN 40'sha
`define GAIN_HUNDRED 40'sh64
`define OFFSET_STEP 40'sh64

// Limits
`define OUT_MAX_MV 16'sh1f40
`define OUT_MIN_MV 16'she0c0
`define OFFSET_MAX 16'sh2710
`define OFFSET_MIN 16'shd8f0

`endif

// file: core/monitor_pkg.sv
// Types shared by the analog monitor scaler files
package monitor_pkg;

  // Raw drive quantities as they arrive
  typedef struct packed {
    logic signed [15:0] motor_speed;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] torque_cmd;
    logic signed [15:0] pos_dev;
    logic signed [15:0] pos_amp_dev;
    logic signed [15:0] pos_cmd_speed;
    logic signed [15:0] speed_ff;
    logic signed [15:0] torque_ff;
    logic positioning_done;
  } quantities_type;

  // Quantities after torque correction, plus control mode
  typedef struct packed {
    logic signed [15:0] motor_speed;
    logic signed [15:0] speed_cmd;
    logic signed [16:0] torque_net;
    logic signed [15:0] pos_dev;
    logic signed [15:0] pos_amp_dev;
    logic signed [15:0] pos_cmd_speed;
    logic signed [15:0] speed_ff;
    logic signed [15:0] torque_ff;
    logic positioning_done;
    logic speed_ctrl;
  } sources_type;

  // One channel's settings
  typedef struct packed {
    logic [4:0] sel;
    logic [3:0] gain;
    logic signed [15:0] offset;
  } chan_cfg_type;

endpackage : monitor_pkg

// file: core/monitor_scale_chan.sv
// One monitor channel: selection, base scale, gain, offset and clamp
`timescale 1ns/1ps
`include "monitor_map.svh"

module monitor_scale_chan
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings and quantities
  input wire monitor_pkg::chan_cfg_type cfg,
  input wire monitor_pkg::sources_type src,
  // Scaled output
  output logic signed [15:0] volt_mv_ff,
  output logic clamped_ff
);

  logic signed [39:0] base_ff;
  logic signed [39:0] nxt_base;
  logic signed [39:0] gained;
  logic signed [39:0] summed;
  logic signed [15:0] nxt_volt_mv;
  logic nxt_clamped;

  // ************************************************************
  // Stage one: selection and base scale
  // ************************************************************

  // Pick the quantity and apply its fixed scale
  always_comb
  begin
    nxt_base = '0;
    case (cfg.sel)
      `SEL_MOTOR_SPEED: nxt_base = 40'(src.motor_speed) * `SCALE_SPEED;
      `SEL_SPEED_CMD: nxt_base = 40'(src.speed_cmd) * `SCALE_SPEED;
      `SEL_TORQUE_CMD: nxt_base = 40'(src.torque_net) * `SCALE_TORQUE;
      `SEL_POS_DEV:
        nxt_base = src.speed_ctrl ? '0 : 40'(src.pos_dev) * `SCALE_DEV;
      `SEL_AMP_DEV:
        nxt_base = src.speed_ctrl ? '0 : 40'(src.pos_amp_dev) * `SCALE_DEV;
      `SEL_POS_CMD_SPEED:
        nxt_base = 40'(src.pos_cmd_speed) * `SCALE_SPEED;
      `SEL_POS_DONE: nxt_base = src.positioning_done ? `DONE_MV : '0;
      `SEL_SPEED_FF: nxt_base = 40'(src.speed_ff) * `SCALE_SPEED;
      `SEL_TORQUE_FF: nxt_base = 40'(src.torque_ff) * `SCALE_TORQUE;
      default: nxt_base = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      base_ff <= '0;
    else
      base_ff <= nxt_base;
  end

  // ************************************************************
  // Stage two: gain, offset and clamp
  // ************************************************************

  always_comb
  begin
    case (cfg.gain)
      `GAIN_X10: gained = base_ff * `GAIN_TEN;
      `GAIN_X100: gained = base_ff * `GAIN_HUNDRED;
      `GAIN_DIV10: gained = base_ff / `GAIN_TEN;
      `GAIN_DIV100: gained = base_ff / `GAIN_HUNDRED;
      default: gained = base_ff;
    endcase
    summed = gained + 40'(cfg.offset) * `OFFSET_STEP;
    nxt_clamped = 1'b1;
    if (summed > 40'(`OUT_MAX_MV))
      nxt_volt_mv = `OUT_MAX_MV;
    else if (summed < 40'(`OUT_MIN_MV))
      nxt_volt_mv = `OUT_MIN_MV;
    else
    begin
      nxt_volt_mv = summed[15:0];
      nxt_clamped = 1'b0;
    end
  end

  // Output register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      volt_mv_ff <= '0;
      clamped_ff <= 1'b0;
    end
    else
    begin
      volt_mv_ff <= nxt_volt_mv;
      clamped_ff <= nxt_clamped;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  property p_speed_pass;
    @(posedge pclk) disable iff (!presetn)
    cfg.sel == `SEL_MOTOR_SPEED |=> base_ff == 40'($past(src.motor_speed));
  endproperty
  a_speed_pass: assert property (p_speed_pass)
    else $error("speed base value wrong");

  property p_done_level;
    @(posedge pclk) disable iff (!presetn)
    (cfg.sel == `SEL_POS_DONE) && src.positioning_done |=>
      base_ff == `DONE_MV;
  endproperty
  a_done_level: assert property (p_done_level)
    else $error("positioning level not 5 V");

  property p_dev_zero;
    @(posedge pclk) disable iff (!presetn)
    src.speed_ctrl && (cfg.sel == `SEL_POS_DEV) |=> base_ff == '0;
  endproperty
  a_dev_zero: assert property (p_dev_zero)
    else $error("deviation not zero in speed mode");

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    (cfg.sel > `SEL_TORQUE_FF) |=> base_ff == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused code not zero");

  property p_limit;
    @(posedge pclk) disable iff (!presetn)
    summed > 40'(`OUT_MAX_MV) |=> volt_mv_ff == `OUT_MAX_MV && clamped_ff;
  endproperty
  a_limit: assert property (p_limit)
    else $error("output not held at upper limit");

  property p_gain_ten;
    @(posedge pclk) disable iff (!presetn)
    (cfg.gain == `GAIN_X10) && (cfg.offset == 16'sh0000) &&
      (base_ff < 40'sh320) && (base_ff > -40'sh320) |=>
      volt_mv_ff == 16'($past(base_ff) * 40'sha);
  endproperty
  a_gain_ten: assert property (p_gain_ten)
    else $error("ten times gain wrong");

endmodule : monitor_scale_chan

// file: dv/monitor_meter.sv
// Meter model that samples both analog monitor channels
`timescale 1ns/1ps

module monitor_meter
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Monitor pins
  input wire logic signed [15:0] volt_one_mv,
  input wire logic signed [15:0] volt_two_mv,
  // Readings
  output logic signed [15:0] read_one_mv,
  output logic signed [15:0] read_two_mv
);
  // Sample both channels once per cycle, like a fast meter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_one_mv <= 16'h0000;
      read_two_mv <= 16'h0000;
    end
    else
    begin
      read_one_mv <= volt_one_mv;
      read_two_mv <= volt_two_mv;
    end
  end
endmodule : monitor_meter

// file: dv/tb.sv
// Testbench for the two-channel analog monitor scaler
`timescale 1ns/1ps
`include "monitor_map.svh"

module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic mode = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic [1:0] clamp;
  logic signed [15:0] mv1;
  logic signed [15:0] mv2;
  logic signed [15:0] rd1;
  logic signed [15:0] rd2;
  monitor_pkg::quantities_type q;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int grav = 0;
  int c;
  int g;

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  analog_monitor_output_scaler i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .drive_in(q), .speed_ctrl_mode(mode),
    .monitor_one_mv(mv1), .monitor_two_mv(mv2), .clamp_active(clamp));

  monitor_meter i_meter (.pclk(pclk), .presetn(presetn),
    .volt_one_mv(mv1), .volt_two_mv(mv2),
    .read_one_mv(rd1), .read_two_mv(rd2));

  // ****************************************
  // Tasks and models
  // ****************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One APB transfer, response checked against the expected error
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", {31'h0, e}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(nm, e, rd);
  endtask : rdc

  // Two scaler stages plus the meter sample
  task automatic outs(int e1, int e2);
    repeat (3) @(posedge pclk);
    #1;
    chk("mon1", 32'(e1), {{16{rd1[15]}}, rd1});
    chk("mon2", 32'(e2), {{16{rd2[15]}}, rd2});
  endtask : outs

  function automatic int base(int k);
    case (k)
      0: return q.motor_speed;
      1: return q.speed_cmd;
      2: return q.torque_cmd - grav;
      3: return mode ? 0 : q.pos_dev * 50;
      4: return mode ? 0 : q.pos_amp_dev * 50;
      5: return q.pos_cmd_speed;
      8: return q.positioning_done ? 5000 : 0;
      9: return q.speed_ff;
      10: return q.torque_ff;
      default: return 0;
    endcase
  endfunction : base

  function automatic int expv(int b, int k, int o);
    int v;
    v = (k == 1) ? b * 10 : (k == 2) ? b * 100 : (k == 3) ? b / 10 :
        (k == 4) ? b / 100 : b;
    v = v + o * 100;
    return (v > 8000) ? 8000 : (v < -8000) ? -8000 : v;
  endfunction : expv

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    q <= {16'h04d2, 16'hfe0c, 16'h012c, 16'h0014, 16'hffe2, 16'h02bc,
         16'hfc7c, 16'h01c2, 1'b1};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (c = 0; c < 7; c++)
      rdc("reset value", 8'(c * 4), (c == 0) ? 32'h2 : 32'h0);
    outs(300, 1234);
    apb(1'b1, `OFF_GRAVITY, 32'h64, 1'b0);
    grav = 100;
    for (c = 0; c < 32; c++)
    begin
      apb(1'b1, `OFF_SEL_ONE, 32'(c), 1'b0);
      apb(1'b1, `OFF_SEL_TWO, 32'(c), 1'b0);
      outs(base(c), base(c));
    end
    @(posedge pclk);
    mode <= 1'b1;
    apb(1'b1, `OFF_SEL_ONE, 32'h3, 1'b0);
    apb(1'b1, `OFF_SEL_TWO, 32'h4, 1'b0);
    outs(0, 0);
    @(posedge pclk);
    mode <= 1'b0;
    q.motor_speed <= 16'hfdc9;
    apb(1'b1, `OFF_SEL_ONE, 32'h0, 1'b0);
    apb(1'b1, `OFF_SEL_TWO, 32'h0, 1'b0);
    for (g = 0; g < 5; g++)
    begin
      apb(1'b1, `OFF_GAIN_ONE, 32'(g), 1'b0);
      apb(1'b1, `OFF_GAIN_TWO, 32'(4 - g), 1'b0);
      outs(expv(-567, g, 0), expv(-567, 4 - g, 0));
      chk("clamp", {30'h0, g == 2, g == 2}, {30'h0, clamp});
    end
    apb(1'b1, `OFF_GAIN_ONE, 32'h5, 1'b1);
    rdc("gain1", `OFF_GAIN_ONE, 32'h4);
    apb(1'b1, `OFF_OFFSET_ONE, 32'h1e, 1'b0);
    apb(1'b1, `OFF_OFFSET_TWO, 32'hd8f0, 1'b0);
    outs(expv(-567, 4, 30), -8000);
    apb(1'b1, `OFF_OFFSET_ONE, 32'h2711, 1'b1);
    rdc("offset1", `OFF_OFFSET_ONE, 32'h1e);
    apb(1'b1, `OFF_OFFSET_TWO, 32'h2710, 1'b0);
    rdc("offset2", `OFF_OFFSET_TWO, 32'h2710);
    apb(1'b1, `OFF_OUT_ONE, 32'h0, 1'b1);
    apb(1'b1, 8'h28, 32'h0, 1'b1);
    apb(1'b0, 8'h02, 32'h0, 1'b1);
    rdc("out1", `OFF_OUT_ONE, 32'h00000bb3);
    q.torque_cmd <= 16'h0208;
    apb(1'b1, `OFF_GAIN_ONE, 32'h1, 1'b0);
    apb(1'b1, `OFF_SEL_ONE, 32'h2, 1'b0);
    outs(7200, 8000);
    rdc("out2", `OFF_OUT_TWO, 32'h00001f40);
    rdc("status", `OFF_STATUS, 32'h00000002);
    stop_test();
  end
endmodule : tb
